/* File: src/rtseq_top.sv */
// Contract
// - 1024 oscillator cycles after power-up delay
// - start-up count only crystal modes, POR/wake
// - PLL mode adds 2 ms lock wait
// - power-up delay after POR pulse, then start-up count
// - RC mode, delay disabled: no time-out
// - time-outs run from POR, not pin
// - power-up delay about 66 ms
// - PLL wait on power-up and wake exit
// - POR loads 0000h and initial flags
// - software brown-out enable resets per config
// - watchdog resets or resumes by power mode
// - pin reset flags depend on power mode
// - stack full resets when enabled
// - underflow sets flag, reset or load
// - interrupt wake clears powerdown, vector or PC+2
// - reset class tells which registers reset
// - watchdog wake keeps registers unmodified
// - delay enabled when disable bit is zero
// - 11-bit delay count on slow oscillator
`timescale 1ns/100ps

module rtseq_top #(
    parameter int unsigned PLL_LOCK_CYCLES = rtseq_pkg::PLL_LOCK_CYCLES
) (
    // clock and reset
    input  wire logic                    clk_sys,
    input  wire logic                    nrst,
    // pins and analog events
    input  wire logic                    por_pulse,
    input  wire logic                    external_reset_n,
    input  wire logic                    oscillator_input_pin,
    input  wire logic                    low_freq_internal_osc,
    input  wire logic                    brownout_active,
    // configuration
    input  wire rtseq_pkg::rtseq_osc_t   osc_mode,
    input  wire logic                    powerup_delay_disable,
    input  wire logic [1:0]              brownout_config,
    input  wire logic                    stack_fault_reset_enable,
    // core state and events
    input  wire rtseq_pkg::rtseq_pmode_t pwr_mode,
    input  wire rtseq_pkg::rtseq_evt_t   events,
    input  wire logic                    high_prio_global_irq_en,
    input  wire logic                    low_prio_global_irq_en,
    input  wire logic [20:0]             pc_current,
    // software access to the status flags
    input  wire logic                    flag_wr_en,
    input  wire rtseq_pkg::rtseq_flags_t flag_wr_data,
    // outputs
    output rtseq_pkg::rtseq_flags_t      flags_q,
    output logic                         core_reset_q,
    output logic                         core_stall_q,
    output logic                         pc_load_q,
    output logic [20:0]                  pc_value_q,
    output rtseq_pkg::rtseq_class_t      reset_class_q,
    output rtseq_pkg::rtseq_state_t      seq_state_q
);

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic is_xtal(input rtseq_pkg::rtseq_osc_t m);
        is_xtal = (m == rtseq_pkg::OSC_LOWPOWER_XTAL) || (m == rtseq_pkg::OSC_MEDIUM_XTAL) ||
                  (m == rtseq_pkg::OSC_HISPEED_XTAL) || (m == rtseq_pkg::OSC_HISPEED_PLL);
    endfunction

    function automatic logic is_pll(input rtseq_pkg::rtseq_osc_t m);
        is_pll = (m == rtseq_pkg::OSC_HISPEED_PLL);
    endfunction

    localparam logic [18:0] POWERUP_DELAY_TIMER_LAST = 19'(rtseq_pkg::POWERUP_DELAY_TIMER_TICKS - 1);
    localparam logic [18:0] OST_LAST  = 19'(rtseq_pkg::OST_TICKS - 1);
    localparam logic [18:0] PLL_LAST  = 19'(PLL_LOCK_CYCLES - 1);

    // ------------------------------------------------------------------
    // edge detection on synchronous inputs
    // ------------------------------------------------------------------
    logic lf_prev_q, osc_prev_q, pin_prev_q, bor_prev_q;
    logic lf_rise, osc_rise, pin_fall, bor_act, bor_rise;

    // brown-out only counts while its configuration lets it act
    always_comb begin
        case (brownout_config)
            rtseq_pkg::BOR_CFG_OFF:   bor_act = 1'b0;
            rtseq_pkg::BOR_CFG_SW:    bor_act = brownout_active & flags_q.sw_brownout_enable;
            rtseq_pkg::BOR_CFG_NOSLP: bor_act = brownout_active & (pwr_mode != rtseq_pkg::PM_SLEEP);
            default:                  bor_act = brownout_active;
        endcase
        lf_rise  = low_freq_internal_osc & ~lf_prev_q;
        osc_rise = oscillator_input_pin & ~osc_prev_q;
        pin_fall = ~external_reset_n & pin_prev_q;
        bor_rise = bor_act & ~bor_prev_q & ~por_pulse;
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            lf_prev_q  <= 1'b0;
            osc_prev_q <= 1'b0;
            pin_prev_q <= 1'b0;
            bor_prev_q <= 1'b0;
        end else begin
            lf_prev_q  <= low_freq_internal_osc;
            osc_prev_q <= oscillator_input_pin;
            pin_prev_q <= external_reset_n;
            bor_prev_q <= bor_act;
        end
    end

    // ------------------------------------------------------------------
    // time-out sequencer
    // ------------------------------------------------------------------
    rtseq_pkg::rtseq_state_t state_d;
    logic [18:0]             cnt_q, cnt_d;
    logic                    wake_q, wake_d;
    rtseq_pkg::rtseq_state_t finish_st;
    rtseq_pkg::rtseq_state_t start_st;

    always_comb begin
        // a wake exit resumes at once; a reset still waits for the pin
        finish_st = (wake_q || external_reset_n) ? rtseq_pkg::ST_RUN : rtseq_pkg::ST_PIN;
        if (!powerup_delay_disable) begin
            start_st = rtseq_pkg::ST_POWERUP_DELAY_TIMER;
        end else if (is_xtal(osc_mode)) begin
            start_st = rtseq_pkg::ST_OST;
        end else begin
            start_st = finish_st;
        end
        state_d = seq_state_q;
        cnt_d   = cnt_q;
        wake_d  = wake_q;
        case (seq_state_q)
            rtseq_pkg::ST_POR, rtseq_pkg::ST_BOR: begin
                cnt_d   = '0;
                wake_d  = 1'b0;
                state_d = start_st;
            end
            rtseq_pkg::ST_POWERUP_DELAY_TIMER: begin
                if (lf_rise) begin
                    cnt_d = cnt_q + 19'h00001;
                    if (cnt_q == POWERUP_DELAY_TIMER_LAST) begin
                        cnt_d   = '0;
                        state_d = is_xtal(osc_mode) ? rtseq_pkg::ST_OST : finish_st;
                    end
                end
            end
            rtseq_pkg::ST_OST: begin
                if (osc_rise) begin
                    cnt_d = cnt_q + 19'h00001;
                    if (cnt_q == OST_LAST) begin
                        cnt_d   = '0;
                        state_d = is_pll(osc_mode) ? rtseq_pkg::ST_PLL : finish_st;
                    end
                end
            end
            rtseq_pkg::ST_PLL: begin
                cnt_d = cnt_q + 19'h00001;
                if (cnt_q == PLL_LAST) begin
                    cnt_d   = '0;
                    state_d = finish_st;
                end
            end
            rtseq_pkg::ST_PIN: begin
                if (external_reset_n) begin
                    state_d = rtseq_pkg::ST_RUN;
                end
            end
            rtseq_pkg::ST_RUN: begin
                wake_d = 1'b0;
                if (events.pm_exit_osc_off && is_xtal(osc_mode)) begin
                    cnt_d   = '0;
                    wake_d  = 1'b1;
                    state_d = rtseq_pkg::ST_OST;
                end
            end
            default: begin
                cnt_d   = '0;
                wake_d  = 1'b0;
                state_d = rtseq_pkg::ST_POR;
            end
        endcase
        // the power-up delay restarts while power is not good
        if (por_pulse) begin
            cnt_d   = '0;
            wake_d  = 1'b0;
            state_d = rtseq_pkg::ST_POR;
        end else if (bor_act) begin
            cnt_d   = '0;
            wake_d  = 1'b0;
            state_d = rtseq_pkg::ST_BOR;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            seq_state_q <= rtseq_pkg::ST_POR;
            cnt_q       <= '0;
            wake_q      <= 1'b0;
        end else begin
            seq_state_q <= state_d;
            cnt_q       <= cnt_d;
            wake_q      <= wake_d;
        end
    end

    // ------------------------------------------------------------------
    // reset causes, status flags and program counter
    // ------------------------------------------------------------------
    rtseq_pkg::rtseq_flags_t flags_d;
    rtseq_pkg::rtseq_class_t class_d;
    logic                    pc_load_d, soft_rst, core_reset_d, core_stall_d;
    logic [20:0]             pc_value_d;
    logic                    running;
    logic                    low_pm;

    always_comb begin
        running    = (seq_state_q == rtseq_pkg::ST_RUN);
        low_pm     = (pwr_mode == rtseq_pkg::PM_IDLE) || (pwr_mode == rtseq_pkg::PM_SLEEP);
        flags_d    = flags_q;
        class_d    = rtseq_pkg::RC_NONE;
        pc_load_d  = 1'b0;
        pc_value_d = pc_value_q;
        soft_rst   = 1'b0;
        // software write first so that a hardware event the same cycle wins
        if (flag_wr_en) begin
            flags_d = flag_wr_data;
        end
        if (por_pulse) begin
            flags_d                    = rtseq_pkg::FLAGS_POR;
            flags_d.sw_brownout_enable = 1'b1;
            class_d                    = rtseq_pkg::RC_POR;
            pc_load_d                  = 1'b1;
            pc_value_d                 = rtseq_pkg::PC_RESET;
        end else if (bor_rise) begin
            flags_d.reset_instr_flag_n      = 1'b1;
            flags_d.watchdog_expired_flag_n = 1'b1;
            flags_d.powerdown_flag_n        = 1'b1;
            flags_d.brownout_flag_n         = 1'b0;
            class_d                         = rtseq_pkg::RC_POR;
            pc_load_d                       = 1'b1;
            pc_value_d                      = rtseq_pkg::PC_RESET;
        end else if (pin_fall && running) begin
            if (low_pm) begin
                flags_d.watchdog_expired_flag_n = 1'b1;
                flags_d.powerdown_flag_n        = 1'b0;
            end else if (pwr_mode == rtseq_pkg::PM_RUN) begin
                flags_d.watchdog_expired_flag_n = 1'b1;
            end
            class_d    = rtseq_pkg::RC_RESET;
            pc_load_d  = 1'b1;
            pc_value_d = rtseq_pkg::PC_RESET;
        end else if (events.watchdog_timeout && running) begin
            flags_d.watchdog_expired_flag_n = 1'b0;
            pc_load_d                       = 1'b1;
            if (low_pm) begin
                flags_d.powerdown_flag_n = 1'b0;
                class_d                  = rtseq_pkg::RC_WAKE;
                pc_value_d               = 21'(pc_current + rtseq_pkg::PC_STEP);
            end else begin
                soft_rst   = 1'b1;
                class_d    = rtseq_pkg::RC_RESET;
                pc_value_d = rtseq_pkg::PC_RESET;
            end
        end else if (events.reset_instr && running) begin
            flags_d.reset_instr_flag_n = 1'b0;
            soft_rst                   = 1'b1;
            class_d                    = rtseq_pkg::RC_RESET;
            pc_load_d                  = 1'b1;
            pc_value_d                 = rtseq_pkg::PC_RESET;
        end else if (events.stack_full && running) begin
            flags_d.stack_full_flag = 1'b1;
            if (stack_fault_reset_enable) begin
                soft_rst   = 1'b1;
                class_d    = rtseq_pkg::RC_RESET;
                pc_load_d  = 1'b1;
                pc_value_d = rtseq_pkg::PC_RESET;
            end
        end else if (events.stack_underflow && running) begin
            flags_d.stack_underflow_flag = 1'b1;
            pc_load_d                    = 1'b1;
            pc_value_d                   = rtseq_pkg::PC_RESET;
            if (stack_fault_reset_enable) begin
                soft_rst = 1'b1;
                class_d  = rtseq_pkg::RC_RESET;
            end
        end else if (events.irq_wake && running) begin
            flags_d.powerdown_flag_n = 1'b0;
            class_d                  = rtseq_pkg::RC_WAKE;
            pc_load_d                = 1'b1;
            if (high_prio_global_irq_en) begin
                pc_value_d = rtseq_pkg::PC_VEC_HI;
            end else if (low_prio_global_irq_en) begin
                pc_value_d = rtseq_pkg::PC_VEC_LO;
            end else begin
                pc_value_d = 21'(pc_current + rtseq_pkg::PC_STEP);
            end
        end
        // the enable bit exists only under software brown-out control
        if (brownout_config != rtseq_pkg::BOR_CFG_SW) begin
            flags_d.sw_brownout_enable = 1'b0;
        end
        core_reset_d = (!(state_d == rtseq_pkg::ST_RUN) && !wake_d) || !external_reset_n || soft_rst;
        core_stall_d = wake_d && (state_d != rtseq_pkg::ST_RUN);
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            flags_q       <= rtseq_pkg::FLAGS_POR;
            core_reset_q  <= 1'b1;
            core_stall_q  <= 1'b0;
            pc_load_q     <= 1'b0;
            pc_value_q    <= rtseq_pkg::PC_RESET;
            reset_class_q <= rtseq_pkg::RC_NONE;
        end else begin
            flags_q       <= flags_d;
            core_reset_q  <= core_reset_d;
            core_stall_q  <= core_stall_d;
            pc_load_q     <= pc_load_d;
            pc_value_q    <= pc_value_d;
            reset_class_q <= class_d;
        end
    end

endmodule // rtseq_top

/* File: src/rtseq_pkg.sv */
package rtseq_pkg;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS   = 5;
    localparam int unsigned PLL_LOCK_NS     = 2000000;
    localparam int unsigned PLL_LOCK_CYCLES = PLL_LOCK_NS / CLK_PERIOD_NS;
    // 2048 ticks of the low-frequency oscillator, about 65.5 ms
    localparam int unsigned POWERUP_DELAY_TIMER_TICKS      = 2048;
    localparam int unsigned OST_TICKS       = 1024;
    localparam int unsigned CNT_W           = 19;

    // ------------------------------------------------------------------
    // program counter values
    // ------------------------------------------------------------------
    localparam int unsigned PC_W       = 21;
    localparam logic [20:0] PC_RESET   = 21'h000000;
    localparam logic [20:0] PC_VEC_HI  = 21'h000008;
    localparam logic [20:0] PC_VEC_LO  = 21'h000018;
    localparam logic [20:0] PC_STEP    = 21'h000002;

    // ------------------------------------------------------------------
    // configuration encodings
    // ------------------------------------------------------------------
    localparam logic [1:0] BOR_CFG_OFF   = 2'h0;
    localparam logic [1:0] BOR_CFG_SW    = 2'h1;
    localparam logic [1:0] BOR_CFG_NOSLP = 2'h2;

    typedef enum logic [3:0] {
        OSC_LOWPOWER_XTAL = 4'h0,
        OSC_MEDIUM_XTAL   = 4'h1,
        OSC_HISPEED_XTAL  = 4'h2,
        OSC_HISPEED_PLL   = 4'h3,
        OSC_EXT_CLOCK     = 4'h4,
        OSC_EXT_CLOCK_IO  = 4'h5,
        OSC_RC            = 4'h6,
        OSC_RC_IO         = 4'h7,
        OSC_INTERNAL_A    = 4'h8,
        OSC_INTERNAL_B    = 4'h9
    } rtseq_osc_t;

    typedef enum logic [1:0] {
        PM_FULL  = 2'h0,
        PM_RUN   = 2'h1,
        PM_IDLE  = 2'h2,
        PM_SLEEP = 2'h3
    } rtseq_pmode_t;

    typedef enum logic [2:0] {
        ST_POR  = 3'h0,
        ST_POWERUP_DELAY_TIMER = 3'h1,
        ST_OST  = 3'h2,
        ST_PLL  = 3'h3,
        ST_PIN  = 3'h4,
        ST_RUN  = 3'h5,
        ST_BOR  = 3'h6
    } rtseq_state_t;

    typedef enum logic [1:0] {
        RC_NONE  = 2'h0,
        RC_POR   = 2'h1,
        RC_RESET = 2'h2,
        RC_WAKE  = 2'h3
    } rtseq_class_t;

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic sw_brownout_enable;
        logic reset_instr_flag_n;
        logic watchdog_expired_flag_n;
        logic powerdown_flag_n;
        logic poweron_flag_n;
        logic brownout_flag_n;
        logic stack_full_flag;
        logic stack_underflow_flag;
    } rtseq_flags_t;

    localparam rtseq_flags_t FLAGS_POR = 8'h70;

    typedef struct packed {
        logic reset_instr;
        logic watchdog_timeout;
        logic stack_full;
        logic stack_underflow;
        logic irq_wake;
        logic pm_exit_osc_off;
    } rtseq_evt_t;

endpackage

/* File: tb/rtseq_osc_model.sv */
`timescale 1ns/100ps

module rtseq_osc_model (
    // clock
    input  wire logic        clk_sys,
    // running totals of rising edges asked for
    input  wire logic [31:0] osc_req,
    input  wire logic [31:0] lf_req,
    // oscillator lines
    output logic             osc_pin,
    output logic             lf_pin
);
    // ------------------------------------------------------------------
    // edge source
    // ------------------------------------------------------------------
    logic [31:0] osc_done = 32'h0;
    logic [31:0] lf_done  = 32'h0;

    // a stopped oscillator rests low, so exact edge counts can be handed out
    initial begin
        osc_pin = 1'b0;
        lf_pin  = 1'b0;
    end

    always @(negedge clk_sys) begin
        if (osc_pin || osc_done == osc_req) begin
            osc_pin <= 1'b0;
        end else begin
            osc_pin  <= 1'b1;
            osc_done <= osc_done + 32'h1;
        end
        if (lf_pin || lf_done == lf_req) begin
            lf_pin <= 1'b0;
        end else begin
            lf_pin  <= 1'b1;
            lf_done <= lf_done + 32'h1;
        end
    end
endmodule // rtseq_osc_model

/* File: tb/rtseq_top_sva.sv */
`timescale 1ns/100ps

module rtseq_top_sva #(
    parameter int unsigned PLL_LOCK_CYCLES = 20
) (
    // clock and reset
    input wire logic                    clk_sys,
    input wire logic                    nrst,
    // watched inputs
    input wire logic                    por_pulse,
    input wire logic                    external_reset_n,
    input wire logic                    brownout_active,
    input wire rtseq_pkg::rtseq_osc_t   osc_mode,
    input wire logic                    powerup_delay_disable,
    // watched outputs
    input wire logic                    core_reset_q,
    input wire logic                    core_stall_q,
    input wire logic                    pc_load_q,
    input wire logic [20:0]             pc_value_q,
    input wire rtseq_pkg::rtseq_class_t reset_class_q,
    input wire rtseq_pkg::rtseq_state_t seq_state_q
);
    // ------------------------------------------------------------------
    // cycles spent in the lock wait
    // ------------------------------------------------------------------
    logic [31:0] pll_cnt_q;
    logic [31:0] pll_cnt_d;

    always_comb begin
        pll_cnt_d = (seq_state_q == rtseq_pkg::ST_PLL) ? pll_cnt_q + 32'h1 : 32'h0;
    end

    always_ff @(posedge clk_sys) begin
        pll_cnt_q <= pll_cnt_d;
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    sequence ost_exit;
        (seq_state_q == rtseq_pkg::ST_OST && !por_pulse && !brownout_active) ##1 seq_state_q != rtseq_pkg::ST_OST;
    endsequence

    sequence pll_exit;
        (seq_state_q == rtseq_pkg::ST_PLL && !por_pulse && !brownout_active) ##1 seq_state_q != rtseq_pkg::ST_PLL;
    endsequence

    por_load_a: assert property ($rose(por_pulse) |-> ##[1:2] (pc_load_q && pc_value_q == rtseq_pkg::PC_RESET
        && reset_class_q == rtseq_pkg::RC_POR)) else $error("power-on did not load the reset vector");
    start_powerup_delay_timer_a: assert property ($fell(por_pulse) && !powerup_delay_disable |=>
        seq_state_q == rtseq_pkg::ST_POWERUP_DELAY_TIMER) else $error("power-up delay did not start");
    no_timeout_a: assert property ($fell(por_pulse) && powerup_delay_disable && external_reset_n
        && osc_mode > rtseq_pkg::OSC_HISPEED_PLL |=> seq_state_q == rtseq_pkg::ST_RUN) else $error("time-out applied");
    pll_follows_a: assert property (ost_exit |-> osc_mode != rtseq_pkg::OSC_HISPEED_PLL
        || seq_state_q == rtseq_pkg::ST_PLL) else $error("lock wait skipped");
    pll_length_a: assert property (pll_exit |-> pll_cnt_q >= PLL_LOCK_CYCLES && pll_cnt_q <= PLL_LOCK_CYCLES + 1)
        else $error("lock wait has the wrong length");
    pin_holds_a: assert property (!external_reset_n && !core_stall_q |=> core_reset_q)
        else $error("core left reset with the pin low");
    core_release_a: assert property ($fell(core_reset_q) |-> seq_state_q == rtseq_pkg::ST_RUN
        && $past(external_reset_n)) else $error("core released early");
    held_reset_a: assert property (seq_state_q != rtseq_pkg::ST_RUN && !core_stall_q |-> core_reset_q)
        else $error("core out of reset during a time-out");
endmodule // rtseq_top_sva

bind rtseq_top rtseq_top_sva #(.PLL_LOCK_CYCLES(PLL_LOCK_CYCLES)) u_sva (.*);

/* File: tb/test_reset_timeout_sequencer.sv */
`timescale 1ns/100ps

module test_reset_timeout_sequencer;
    // ------------------------------------------------------------------
    // signals
    // ------------------------------------------------------------------
    localparam int unsigned PLL_N = 20;
    logic                    clk_sys = 1'b0;
    logic                    nrst = 1'b0;
    logic                    por_pulse = 1'b1;
    logic                    external_reset_n = 1'b1;
    logic                    oscillator_input_pin;
    logic                    low_freq_internal_osc;
    logic                    brownout_active = 1'b0;
    logic [20:0]             pc_current = 21'h100;
    logic [31:0]             osc_req = 32'h0;
    logic [31:0]             lf_req = 32'h0;
    rtseq_pkg::rtseq_osc_t   osc_mode = rtseq_pkg::OSC_HISPEED_XTAL;
    logic                    powerup_delay_disable = 1'b0;
    logic [1:0]              brownout_config = 2'h0;
    logic                    stack_fault_reset_enable = 1'b0;
    rtseq_pkg::rtseq_pmode_t pwr_mode = rtseq_pkg::PM_FULL;
    rtseq_pkg::rtseq_evt_t   events = 6'h00;
    logic                    high_prio_global_irq_en = 1'b0;
    logic                    low_prio_global_irq_en = 1'b0;
    logic                    flag_wr_en = 1'b0;
    rtseq_pkg::rtseq_flags_t flag_wr_data = 8'h00;
    rtseq_pkg::rtseq_flags_t flags_q;
    logic                    core_reset_q;
    logic                    core_stall_q;
    logic                    pc_load_q;
    logic [20:0]             pc_value_q;
    rtseq_pkg::rtseq_class_t reset_class_q;
    rtseq_pkg::rtseq_state_t seq_state_q;
    int                      mismatches = 0;
    int                      samples_checked = 0;
    int                      n;

    always #2.5 clk_sys = ~clk_sys;

    rtseq_osc_model osc (.clk_sys(clk_sys), .osc_req(osc_req), .lf_req(lf_req), .osc_pin(oscillator_input_pin),
                         .lf_pin(low_freq_internal_osc));

    rtseq_top #(.PLL_LOCK_CYCLES(PLL_N)) dut (.*);

    // ------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic cycles(input int k);
        repeat (k) @(negedge clk_sys);
    endtask

    task automatic wait_state(input rtseq_pkg::rtseq_state_t s, input int bound);
        for (int i = 0; i < bound && seq_state_q !== s; i++) @(negedge clk_sys);
        check(seq_state_q, s);
        if (seq_state_q !== s) finish_test();
    endtask

    task automatic power_on(input rtseq_pkg::rtseq_osc_t m, input logic dis);
        osc_mode = m;
        powerup_delay_disable = dis;
        por_pulse = 1'b1;
        cycles(3);
        por_pulse = 1'b0;
        cycles(1);
    endtask

    // ctl is {high enable, low enable, stack fault reset enable}
    task automatic run_event(input logic [1:0] pm, input rtseq_pkg::rtseq_evt_t ev, input logic pin,
                             input logic [2:0] ctl, input logic [7:0] base, input logic [7:0] exp_f,
                             input logic [20:0] exp_pc, input logic [1:0] exp_c);
        pwr_mode = rtseq_pkg::rtseq_pmode_t'(pm);
        {high_prio_global_irq_en, low_prio_global_irq_en, stack_fault_reset_enable} = ctl;
        flag_wr_en = 1'b1;
        flag_wr_data = base;
        cycles(1);
        flag_wr_en = 1'b0;
        events = ev;
        external_reset_n = ~pin;
        cycles(1);
        events = 6'h00;
        external_reset_n = 1'b1;
        check(pc_load_q, 1'b1);
        check(pc_value_q, exp_pc);
        check(flags_q, exp_f);
        check(core_reset_q, exp_c == 2'h2);
        if (exp_c != 2'h0) check(reset_class_q, exp_c);
        wait_state(rtseq_pkg::ST_RUN, 50);
    endtask

    // ------------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------------
    initial begin
        cycles(8);
        nrst = 1'b1;
        power_on(rtseq_pkg::OSC_HISPEED_XTAL, 1'b0);
        check(seq_state_q, rtseq_pkg::ST_POWERUP_DELAY_TIMER);
        check(flags_q, rtseq_pkg::FLAGS_POR);
        // crystal edges during the delay must not shorten the start-up count
        osc_req = 32'd1024;
        lf_req = 32'd2047;
        cycles(4200);
        check(seq_state_q, rtseq_pkg::ST_POWERUP_DELAY_TIMER);
        lf_req = 32'd2048;
        wait_state(rtseq_pkg::ST_OST, 8);
        osc_req = 32'd2047;
        cycles(2100);
        check(seq_state_q, rtseq_pkg::ST_OST);
        osc_req = 32'd2048;
        wait_state(rtseq_pkg::ST_RUN, 8);
        check(core_reset_q, 1'b0);
        $display("power-up done");
        events = 6'h01;
        cycles(1);
        events = 6'h00;
        check(seq_state_q, rtseq_pkg::ST_OST);
        check({core_stall_q, core_reset_q}, 2'h2);
        osc_req = 32'd3072;
        wait_state(rtseq_pkg::ST_RUN, 2100);
        check(core_stall_q, 1'b0);
        $display("wake done");
        brownout_config = 2'h1;
        external_reset_n = 1'b0;
        power_on(rtseq_pkg::OSC_HISPEED_PLL, 1'b1);
        check(seq_state_q, rtseq_pkg::ST_OST);
        check(flags_q, 8'hf0);
        osc_req = 32'd4096;
        wait_state(rtseq_pkg::ST_PLL, 2100);
        for (n = 0; n < 100 && seq_state_q === rtseq_pkg::ST_PLL; n++) cycles(1);
        check(n >= PLL_N && n <= PLL_N + 1, 1'b1);
        check(seq_state_q, rtseq_pkg::ST_PIN);
        check(core_reset_q, 1'b1);
        external_reset_n = 1'b1;
        wait_state(rtseq_pkg::ST_RUN, 3);
        check(core_reset_q, 1'b0);
        $display("lock done");
        brownout_config = 2'h0;
        for (int m = 0; m < 10; m++) begin
            power_on(rtseq_pkg::rtseq_osc_t'(m), 1'b1);
            check(seq_state_q, m < 4 ? rtseq_pkg::ST_OST : rtseq_pkg::ST_RUN);
        end
        power_on(rtseq_pkg::OSC_EXT_CLOCK, 1'b0);
        check(seq_state_q, rtseq_pkg::ST_POWERUP_DELAY_TIMER);
        lf_req = 32'd4096;
        wait_state(rtseq_pkg::ST_RUN, 4200);
        $display("modes done");
        run_event(2'h0, 6'h10, 1'b0, 3'h0, 8'h7c, 8'h5c, 21'h0, 2'h2);
        run_event(2'h1, 6'h10, 1'b0, 3'h0, 8'h7c, 8'h5c, 21'h0, 2'h2);
        run_event(2'h2, 6'h10, 1'b0, 3'h0, 8'h7c, 8'h4c, 21'h102, 2'h3);
        run_event(2'h3, 6'h10, 1'b0, 3'h0, 8'h7c, 8'h4c, 21'h102, 2'h3);
        run_event(2'h0, 6'h20, 1'b0, 3'h0, 8'hfc, 8'h3c, 21'h0, 2'h2);
        run_event(2'h0, 6'h08, 1'b0, 3'h1, 8'h7c, 8'h7e, 21'h0, 2'h2);
        run_event(2'h0, 6'h04, 1'b0, 3'h1, 8'h7c, 8'h7d, 21'h0, 2'h2);
        run_event(2'h0, 6'h04, 1'b0, 3'h0, 8'h7c, 8'h7d, 21'h0, 2'h0);
        run_event(2'h3, 6'h02, 1'b0, 3'h4, 8'h7c, 8'h6c, 21'h8, 2'h3);
        run_event(2'h2, 6'h02, 1'b0, 3'h2, 8'h7c, 8'h6c, 21'h18, 2'h3);
        run_event(2'h2, 6'h02, 1'b0, 3'h0, 8'h7c, 8'h6c, 21'h102, 2'h3);
        run_event(2'h2, 6'h00, 1'b1, 3'h0, 8'h5c, 8'h6c, 21'h0, 2'h2);
        run_event(2'h1, 6'h00, 1'b1, 3'h0, 8'h5c, 8'h7c, 21'h0, 2'h2);
        run_event(2'h0, 6'h00, 1'b1, 3'h0, 8'h5c, 8'h5c, 21'h0, 2'h2);
        $display("events done");
        finish_test();
    end
endmodule // test_reset_timeout_sequencer
